// ---- pkg/dmc_pkg.sv ----
// Package: register map, field positions and reset values for the DPLL mode control block
package dmc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] DMC_ADDR_WIDTH = 8'h08;
  localparam logic [7:0] DMC_OFF_MODE_TWO = 8'h00;   // dpll_mode_control_two
  localparam logic [7:0] DMC_OFF_STATUS = 8'h01;     // Sticky event status, read only
  localparam logic [7:0] DMC_OFF_CLEAR = 8'h02;      // Write one to clear status
  localparam logic [7:0] DMC_OFF_ENABLE = 8'h03;     // Interrupt enable
  localparam logic [7:0] DMC_OFF_STATE = 8'h04;      // Live block state

  // ****************************************
  // Mode register fields
  // ****************************************
  localparam int DMC_UNUSED_HI = 15;
  localparam int DMC_UNUSED_LO = 12;
  localparam int DMC_HOLD_RST_BIT = 11;
  localparam int DMC_TIE_RST_BIT = 10;
  localparam int DMC_FDS_HI = 9;
  localparam int DMC_FDS_LO = 8;
  localparam int DMC_FAIL2_EN_BIT = 7;
  localparam int DMC_FAIL1_EN_BIT = 6;
  localparam int DMC_INV_BIT = 5;
  localparam logic [15:0] DMC_MODE_RESET = 16'h0000;
  localparam logic [15:0] DMC_MODE_MASK = 16'h0FE0;  // Bits this block keeps

  // ****************************************
  // Event bits (status, clear, enable)
  // ****************************************
  localparam int DMC_EV_FREERUN = 0;     // Holdover forced to freerun
  localparam int DMC_EV_SEL_CHANGE = 1;  // Selected reference changed
  localparam int DMC_EV_RESVD_WRITE = 2; // Nonzero write to unused bits
  localparam int DMC_EV_NUM = 3;

  // Failure detect modes
  typedef enum logic [1:0]
  {
    DMC_FD_AUTO = 2'h0,
    DMC_FD_EXTERNAL = 2'h1,
    DMC_FD_FORCE_PRI = 2'h2,
    DMC_FD_FORCE_SEC = 2'h3
  } dmc_fd_mode_t;

endpackage

// ---- rtl/dmc_ref_select.sv ----
// Reference selection from failure detect mode and loss indications
module dmc_ref_select
  import dmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic [1:0] mode,
  // Loss indications
  input wire logic monitor_pri_loss,
  input wire logic monitor_sec_loss,
  input wire logic primary_loss_input,
  input wire logic secondary_loss_input,
  // Result
  output logic use_secondary,
  output logic pri_fail,
  output logic sec_fail
);

  // Choose the loss source for a mode
  function automatic logic pick_loss(input logic [1:0] m, input logic mon, input logic ext);
    pick_loss = (dmc_fd_mode_t'(m) == DMC_FD_EXTERNAL) ? ext : mon;
  endfunction

  logic next_use_secondary;
  logic pri_loss;
  logic sec_loss;

  // Loss source follows the mode
  always_comb
  begin
    pri_loss = pick_loss(mode, monitor_pri_loss, primary_loss_input);
    sec_loss = pick_loss(mode, monitor_sec_loss, secondary_loss_input);
  end

  // Selection: forced modes ignore failure state entirely
  always_comb
  begin
    case (dmc_fd_mode_t'(mode))
      DMC_FD_AUTO, DMC_FD_EXTERNAL:
        // Stay on secondary only while primary is down and secondary is good
        next_use_secondary = pri_loss & ~sec_loss;
      DMC_FD_FORCE_PRI:
        next_use_secondary = 1'b0;
      DMC_FD_FORCE_SEC:
        next_use_secondary = 1'b1;
      default:
        next_use_secondary = 1'b0;
    endcase
  end

  // Registered result
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      use_secondary <= 1'b0;
      pri_fail <= 1'b0;
      sec_fail <= 1'b0;
    end
    else
    begin
      use_secondary <= next_use_secondary;
      pri_fail <= pri_loss;
      sec_fail <= sec_loss;
    end
  end

endmodule

// ---- rtl/dmc_mode_control.sv ----
// Top: upper half of the second DPLL operation mode control register and its effects
//
// What this block does
// - Holdover memory runs normally while its reset bit is low.
// - Holdover memory held in reset while its reset bit is high.
// - In holdover, a pulse or high level on that bit forces freerun.
// - Error correction circuit runs normally while its reset bit is low.
// - Reset bit high: correction held in reset, outputs align to nearest edge.
// - Mode 00 uses internal monitor; 01 uses external loss inputs.
// - Mode 10 forces primary, 11 forces secondary, whatever the failures.
// - Second failure output driven only while its enable bit is high.
// - First failure output driven only while its enable bit is high.
module dmc_mode_control
  import dmc_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // DPLL state from the loop core
  input wire logic DPLL_IN_HOLDOVER,
  input wire logic MONITOR_PRI_LOSS,
  input wire logic MONITOR_SEC_LOSS,
  // External loss inputs
  input wire logic PRIMARY_LOSS_INPUT,
  input wire logic SECONDARY_LOSS_INPUT,
  // Backplane references
  input wire logic BACKPLANE_REF_IN_ONE,
  input wire logic BACKPLANE_REF_IN_TWO,
  output logic DPLL_REF_ONE,
  output logic DPLL_REF_TWO,
  // DPLL controls
  output logic HOLDOVER_MEMORY_RESET,
  output logic TIE_CORRECTION_RESET,
  output logic ALIGN_NEAREST_EDGE,
  output logic FORCE_FREERUN,
  output logic USE_SECONDARY,
  // Failure indication pins
  output logic FAIL_ONE_OUT,
  output logic FAIL_ONE_OE,
  output logic FAIL_TWO_OUT,
  output logic FAIL_TWO_OE,
  // Interrupt
  output logic IRQ
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [15:0] mode_reg;
  logic [DMC_EV_NUM-1:0] status;
  logic [DMC_EV_NUM-1:0] irq_enable;
  logic wr_mode;
  logic wr_clear;
  logic wr_enable;
  logic [DMC_EV_NUM-1:0] events;
  logic [DMC_EV_NUM-1:0] clear_bits;

  // Word match; only the exact offset hits, so words above the map stay silent
  function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
    hits = (a == off);
  endfunction

  // Write decode; a strobe only counts with the address it stands beside
  always_comb
  begin
    wr_mode = WR && hits(ADDR, DMC_OFF_MODE_TWO);
    wr_clear = WR && hits(ADDR, DMC_OFF_CLEAR);
    wr_enable = WR && hits(ADDR, DMC_OFF_ENABLE);
    clear_bits = wr_clear ? WDATA[DMC_EV_NUM-1:0] : '0;
  end

  // Mode register; unused and low bits are kept out so they read as zero
  // Limitation: bits 4 to 0 belong to another block and are not stored here
  // Every field of this word but the failure detect mode acts one cycle after the write lands; the mode takes two
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      mode_reg <= DMC_MODE_RESET;
    else if (wr_mode)
      mode_reg <= WDATA & DMC_MODE_MASK;
  end

  // Field views
  logic hold_rst;
  logic tie_rst;
  logic [1:0] fd_sel;
  logic fail2_en;
  logic fail1_en;
  logic invert;

  always_comb
  begin
    hold_rst = mode_reg[DMC_HOLD_RST_BIT];
    tie_rst = mode_reg[DMC_TIE_RST_BIT];
    fd_sel = mode_reg[DMC_FDS_HI:DMC_FDS_LO];
    fail2_en = mode_reg[DMC_FAIL2_EN_BIT];
    fail1_en = mode_reg[DMC_FAIL1_EN_BIT];
    invert = mode_reg[DMC_INV_BIT];
  end

  // ****************************************
  // Reference selection
  // ****************************************
  logic use_sec;
  logic pri_fail;
  logic sec_fail;

  // Selection is registered in the selector, then once more for the pin
  dmc_ref_select u_sel
  (
    .clk(REF_CLK),
    .rst(RESET),
    .mode(fd_sel),
    .monitor_pri_loss(MONITOR_PRI_LOSS),
    .monitor_sec_loss(MONITOR_SEC_LOSS),
    .primary_loss_input(PRIMARY_LOSS_INPUT),
    .secondary_loss_input(SECONDARY_LOSS_INPUT),
    .use_secondary(use_sec),
    .pri_fail(pri_fail),
    .sec_fail(sec_fail)
  );

  // ****************************************
  // DPLL control outputs
  // ****************************************
  logic use_sec_q;

  // Controls registered once so every output comes from a flip-flop
  // Slave operation relies on software keeping the correction reset high
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      HOLDOVER_MEMORY_RESET <= 1'b0;
      TIE_CORRECTION_RESET <= 1'b0;
      ALIGN_NEAREST_EDGE <= 1'b0;
      FORCE_FREERUN <= 1'b0;
      USE_SECONDARY <= 1'b0;
      use_sec_q <= 1'b0;
    end
    else
    begin
      // Low runs the memory, high holds it in reset
      HOLDOVER_MEMORY_RESET <= hold_rst;
      // Correction reset also asks the loop to snap to the nearest edge
      TIE_CORRECTION_RESET <= tie_rst;
      ALIGN_NEAREST_EDGE <= tie_rst;
      // Even a one-cycle pulse lands here, so a short write still takes effect
      FORCE_FREERUN <= DPLL_IN_HOLDOVER & hold_rst;
      USE_SECONDARY <= use_sec;
      use_sec_q <= use_sec;
    end
  end

  // ****************************************
  // Backplane reference inversion
  // ****************************************
  // One flop of latency on the references; the loop tolerates a fixed delay
  // Limitation: a reference must stay below half the clock rate to be seen at all
  logic [1:0] ref_in;
  logic [1:0] ref_q;

  // Index 0 is the first backplane reference, index 1 the second
  always_comb
  begin
    ref_in = {BACKPLANE_REF_IN_TWO, BACKPLANE_REF_IN_ONE};
  end

  for (genvar r = 0; r < 2; r++)
  begin : g_ref_inv
    always_ff @(posedge REF_CLK)
    begin
      if (RESET)
        ref_q[r] <= 1'b0;
      else
        ref_q[r] <= ref_in[r] ^ invert;
    end
  end

  // Output pins straight from those flops
  always_comb
  begin
    DPLL_REF_ONE = ref_q[0];
    DPLL_REF_TWO = ref_q[1];
  end

  // ****************************************
  // Failure indication pins
  // ****************************************
  // Pin 0 carries primary loss on the first output, pin 1 secondary loss on the second
  logic [1:0] pin_en;
  logic [1:0] pin_loss;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;

  // Gather enables and loss flags so both pins share one piece of logic
  always_comb
  begin
    pin_en = {fail2_en, fail1_en};
    pin_loss = {sec_fail, pri_fail};
  end

  // Data held low while disabled so nothing leaks when enabled later
  for (genvar p = 0; p < 2; p++)
  begin : g_fail_pin
    always_ff @(posedge REF_CLK)
    begin
      if (RESET)
      begin
        pin_out[p] <= 1'b0;
        pin_oe[p] <= 1'b0;
      end
      else
      begin
        pin_out[p] <= pin_en[p] & pin_loss[p];
        pin_oe[p] <= pin_en[p];
      end
    end
  end

  // Pins are plain wires from the flops above
  always_comb
  begin
    FAIL_ONE_OUT = pin_out[0];
    FAIL_ONE_OE = pin_oe[0];
    FAIL_TWO_OUT = pin_out[1];
    FAIL_TWO_OE = pin_oe[1];
  end

  // ****************************************
  // Events and interrupt
  // ****************************************
  always_comb
  begin
    events = '0;
    events[DMC_EV_FREERUN] = DPLL_IN_HOLDOVER & hold_rst;
    events[DMC_EV_SEL_CHANGE] = use_sec ^ use_sec_q;
    // Flags software that broke the zero-write convention
    events[DMC_EV_RESVD_WRITE] = wr_mode && (WDATA[DMC_UNUSED_HI:DMC_UNUSED_LO] != 4'h0);
  end

  // Sticky status; a new event wins over a clear in the same cycle
  // Clear is write-one per bit, so untouched bits keep their history
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      status <= '0;
    else
      status <= (status & ~clear_bits) | events;
  end

  // Interrupt enable register
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      irq_enable <= '0;
    else if (wr_enable)
      irq_enable <= WDATA[DMC_EV_NUM-1:0];
  end

  // Level interrupt, one cycle behind status
  // Disabling masks the pin without losing the event in status
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      IRQ <= 1'b0;
    else
      IRQ <= |(status & irq_enable);
  end

  // ****************************************
  // Read port
  // ****************************************
  // Unmapped and write-only addresses read zero
  // Data stands for one cycle only, so a stale word never lingers on the bus
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      RDATA <= 16'h0000;
    else if (RD)
    begin
      case (ADDR)
        DMC_OFF_MODE_TWO: RDATA <= mode_reg;
        DMC_OFF_STATUS: RDATA <= {13'h0000, status};
        DMC_OFF_ENABLE: RDATA <= {13'h0000, irq_enable};
        DMC_OFF_STATE: RDATA <= {11'h000, FORCE_FREERUN, ALIGN_NEAREST_EDGE,
                                 USE_SECONDARY, sec_fail, pri_fail};
        default: RDATA <= 16'h0000;
      endcase
    end
    else
      RDATA <= 16'h0000;
  end

endmodule

// ---- test/dmc_ref_src.sv ----
// Partner model: backplane reference clock sources
module dmc_ref_src
(
  // Clock and control
  input wire logic clk,
  input wire logic run,
  input wire logic [1:0] lvl,
  // Reference outputs
  output logic ref_one,
  output logic ref_two
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt = 2'h0;
  // Divider; the two refs differ in rate so a swapped pair shows up
  always @(posedge clk)
  begin
    cnt <= cnt + 2'h1;
  end
  // Stopped sources rest at the level the bench asks for
  always_comb
  begin
    ref_one = run ? cnt[0] : lvl[1];
    ref_two = run ? cnt[1] : lvl[0];
  end
endmodule

// ---- test/dmc_mode_control_properties.sv ----
// Checker: port-level properties of the DPLL mode control block
module dmc_mode_control_chk
  import dmc_pkg::*;
(
  // Clock, reset and register port
  input wire logic REF_CLK, RESET, WR, RD,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA, RDATA,
  // Loop state and references
  input wire logic DPLL_IN_HOLDOVER, PRIMARY_LOSS_INPUT, SECONDARY_LOSS_INPUT,
  input wire logic BACKPLANE_REF_IN_ONE, BACKPLANE_REF_IN_TWO,
  // Controls under watch
  input wire logic DPLL_REF_ONE, DPLL_REF_TWO, HOLDOVER_MEMORY_RESET, TIE_CORRECTION_RESET,
  input wire logic ALIGN_NEAREST_EDGE, FORCE_FREERUN, USE_SECONDARY, FAIL_ONE_OE, FAIL_TWO_OE
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] sh;
  logic live;
  // ********
  // Shadow of the mode register
  // ********
  // Rebuilt from the strobe alone, so a stuck register shows; live masks reset edges
  always_ff @(posedge REF_CLK)
  begin
    live <= !RESET;
    if (RESET)
      sh <= 16'h0000;
    else if (WR && ADDR == DMC_OFF_MODE_TWO)
      sh <= WDATA & DMC_MODE_MASK;
  end
  // ********
  // Properties
  // ********
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  chk_hold_follow:
    assert property (live |-> HOLDOVER_MEMORY_RESET == $past(sh[11])) else $error("hold reset");
  chk_tie_align:
    assert property (live |-> {TIE_CORRECTION_RESET, ALIGN_NEAREST_EDGE} == {2{$past(sh[10])}})
      else $error("tie reset");
  chk_freerun_force:
    assert property (live |-> FORCE_FREERUN == ($past(DPLL_IN_HOLDOVER) && $past(sh[11])))
      else $error("freerun");
  chk_ext_select:
    assert property ((sh[9:8] == 2'h1 && PRIMARY_LOSS_INPUT && !SECONDARY_LOSS_INPUT)[*3]
      |-> USE_SECONDARY) else $error("external select");
  chk_forced_pri:
    assert property ((sh[9:8] == 2'h2)[*3] |-> !USE_SECONDARY) else $error("forced primary");
  chk_forced_sec:
    assert property ((sh[9:8] == 2'h3)[*3] |-> USE_SECONDARY) else $error("forced secondary");
  chk_fail_enable:
    assert property (live |-> {FAIL_TWO_OE, FAIL_ONE_OE} == $past(sh[7:6])) else $error("fail oe");
  chk_ref_invert:
    assert property (live |-> {DPLL_REF_ONE, DPLL_REF_TWO} == ({$past(BACKPLANE_REF_IN_ONE),
      $past(BACKPLANE_REF_IN_TWO)} ^ {2{$past(sh[5])}})) else $error("invert");
  chk_mode_readback:
    assert property ($past(RD) && $past(ADDR) == DMC_OFF_MODE_TWO |-> RDATA == $past(sh))
      else $error("readback");
  // Main scenarios reached
  cov_freerun: cover property (FORCE_FREERUN);
  cov_secondary: cover property (USE_SECONDARY && FAIL_ONE_OE);
  cov_align: cover property (ALIGN_NEAREST_EDGE);
endmodule
bind dmc_mode_control dmc_mode_control_chk chk (.REF_CLK, .RESET, .WR, .RD, .ADDR, .WDATA,
  .RDATA, .DPLL_IN_HOLDOVER, .PRIMARY_LOSS_INPUT, .SECONDARY_LOSS_INPUT, .BACKPLANE_REF_IN_ONE,
  .BACKPLANE_REF_IN_TWO, .DPLL_REF_ONE, .DPLL_REF_TWO, .HOLDOVER_MEMORY_RESET,
  .TIE_CORRECTION_RESET, .ALIGN_NEAREST_EDGE, .FORCE_FREERUN, .USE_SECONDARY, .FAIL_ONE_OE,
  .FAIL_TWO_OE);

// ---- test/testbench.sv ----
// Testbench: register, selection and interrupt checks of the DPLL mode control block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import dmc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hold = 1'b0;
  logic run = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic [1:0] mon = 2'h0;
  logic [1:0] ext = 2'h0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic ref1, ref2, d1, d2, hr, tr, al, fr, us, f1, o1, f2, o2, irq;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // Cases: mode word, {holdover, ref levels, external losses}, expected controls
  logic [15:0] row_mode [6] = '{16'h0000, 16'h0820, 16'h0540, 16'h0280, 16'h03E0, 16'h0180};
  logic [4:0] row_in [6] = '{5'h18, 5'h18, 5'h02, 5'h02, 5'h08, 5'h01};
  logic [15:0] row_exp [6] = '{16'h0008, 16'h0904, 16'h06C2, 16'h0020, 16'h00A6, 16'h0030};
  wire [15:0] outs = {4'h0, hr, tr, al, fr, o1, f1, o2, f2, d1, d2, us, irq};
  dmc_ref_src src (.clk(clk), .run(run), .lvl(lvl), .ref_one(ref1), .ref_two(ref2));
  dmc_mode_control uut (.REF_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .DPLL_IN_HOLDOVER(hold), .MONITOR_PRI_LOSS(mon[1]),
    .MONITOR_SEC_LOSS(mon[0]), .PRIMARY_LOSS_INPUT(ext[1]), .SECONDARY_LOSS_INPUT(ext[0]),
    .BACKPLANE_REF_IN_ONE(ref1), .BACKPLANE_REF_IN_TWO(ref2), .DPLL_REF_ONE(d1),
    .DPLL_REF_TWO(d2), .HOLDOVER_MEMORY_RESET(hr), .TIE_CORRECTION_RESET(tr),
    .ALIGN_NEAREST_EDGE(al), .FORCE_FREERUN(fr), .USE_SECONDARY(us), .FAIL_ONE_OUT(f1),
    .FAIL_ONE_OE(o1), .FAIL_TWO_OUT(f2), .FAIL_TWO_OE(o2), .IRQ(irq));
  // 4 ns clock
  always #2 clk = ~clk;
  // Watchdog: the run needs about 120 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      results();
    end
  end
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write cycle plus idle cycle, so strobes never collide
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Read, data taken in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(rdata, e);
  endtask
  // Counts and verdict
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(outs, 16'h0000);
    rd_chk(DMC_OFF_MODE_TWO, DMC_MODE_RESET);
    foreach (row_mode[i])
    begin
      {hold, lvl, ext} <= row_in[i];
      bus_wr(DMC_OFF_MODE_TWO, row_mode[i]);
      repeat (3) @(posedge clk);
      chk(outs, row_exp[i]);
      rd_chk(DMC_OFF_MODE_TWO, row_mode[i]);
    end
    // Auto mode follows the monitor; both lost stays on primary
    ext <= 2'h0;
    bus_wr(DMC_OFF_MODE_TWO, 16'h0000);
    mon <= 2'h2;
    repeat (3) @(posedge clk);
    chk({15'h0000, us}, 16'h0001);
    mon <= 2'h3;
    repeat (3) @(posedge clk);
    chk({15'h0000, us}, 16'h0000);
    // Holdover pulse forces freerun, sets status and raises the interrupt
    mon <= 2'h0;
    hold <= 1'b1;
    bus_wr(DMC_OFF_CLEAR, 16'h0007);
    bus_wr(DMC_OFF_ENABLE, 16'h0001);
    bus_wr(DMC_OFF_MODE_TWO, 16'h0800);
    bus_wr(DMC_OFF_MODE_TWO, 16'h0000);
    repeat (3) @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    rd_chk(DMC_OFF_STATUS, 16'h0001);
    bus_wr(DMC_OFF_ENABLE, 16'h0000);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    bus_wr(DMC_OFF_ENABLE, 16'h0001);
    bus_wr(DMC_OFF_CLEAR, 16'h0001);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    rd_chk(DMC_OFF_STATUS, 16'h0000);
    // Unused bits are dropped and flagged; an unmapped word reads zero
    hold <= 1'b0;
    bus_wr(DMC_OFF_MODE_TWO, 16'hF000);
    rd_chk(DMC_OFF_MODE_TWO, 16'h0000);
    rd_chk(DMC_OFF_STATUS, 16'h0004);
    rd_chk(8'h07, 16'h0000);
    // A selection change that meets a clear in the same cycle stays set
    bus_wr(DMC_OFF_CLEAR, 16'h0007);
    bus_wr(DMC_OFF_MODE_TWO, 16'h0300);
    bus_wr(DMC_OFF_CLEAR, 16'h0002);
    rd_chk(DMC_OFF_STATUS, 16'h0002);
    // Running references through the inversion, watched by the checker
    run <= 1'b1;
    bus_wr(DMC_OFF_MODE_TWO, 16'h0020);
    repeat (8) @(posedge clk);
    run <= 1'b0;
    // Second reset in mid-run clears register and controls, which then stay clear
    bus_wr(DMC_OFF_MODE_TWO, 16'h0FE0);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(outs, 16'h0000);
    @(posedge clk);
    chk(outs, 16'h0000);
    rd_chk(DMC_OFF_MODE_TWO, DMC_MODE_RESET);
    results();
  end
endmodule
